/* File: design/disk_tag_drive.sv */
// Purpose: Drive side of the tag bus, sector timing and status lines
// Assumes: All inputs come from pins or sensors outside clk_sys
// Notes:   Every input but clk_sys and reset_n passes a two-stage synchroniser first

// Notes on behaviour
// - Three-bit unit address, presence line when fitted
// - Address stable 200 ns around presence
// - Presence follows plug insertion
// - Sector count steps on sector, clears on index
// - Count capped at 29 or 31
// - One index per turn, starts sector zero
// - Sector mark pulse 1.25 us wide
// - Fault output on any of five causes
// - Any fault blocks writing at once
// - Latched causes clear only once gone
// - Seek error on timeout, field exit, range
// - Range error fast, travel one track
// - Return to zero clears seek error
// - On cylinder drops for seeks and offsets
// - Ready needs speed, loaded heads, no fault
// - Write protect blocks and flags writes
// - First tag carries cylinder address
// - Second tag carries head number
// - Control bits for write and read gates
// - Control bits for servo offsets
// - Control bits for fault clear, zero return
module disk_tag_drive
  import disk_tag_pkg::*;
#(
  parameter int OFFSET_CYC       = OFFSET_NS / CLK_PERIOD_NS,
  parameter int SEEK_TIMEOUT_CYC = SEEK_TIMEOUT_NS / CLK_PERIOD_NS
) (
  input  wire logic          clk_sys,
  input  wire logic          reset_n,
  input  wire logic [2:0]    addrPlugIn,
  input  wire logic          plugFittedIn,
  input  wire logic [2:0]    tagIn,
  input  wire logic [9:0]    busIn,
  input  wire logic          sect32SelIn,
  input  wire logic          servoIndexIn,
  input  wire logic          servoSectorIn,
  input  wire logic          dcPowerFaultIn,
  input  wire logic          multiHeadIn,
  input  wire logic          writeCurrentFaultIn,
  input  wire logic          outOfFieldIn,
  input  wire logic          carriageArrivedIn,
  input  wire logic          speedOkIn,
  input  wire logic          headsLoadedIn,
  input  wire logic          writeProtectSwIn,
  input  wire logic          faultClearSwIn,
  input  wire logic          driveInitIn,
  output logic [2:0]         unitAddr,
  output logic               plugValid,
  output logic [4:0]         sectorCount,
  output logic               indexPulse,
  output logic               sectorMark,
  output drive_status_t      status,
  output logic               writeEnable,
  output logic               readEnable,
  output logic [2:0]         headSel,
  output logic               offsetPlus,
  output logic               offsetMinus,
  output logic               write_lock_error
);
  localparam int SYNC_W = 30;
  localparam int TMR_W  = $clog2(SEEK_TIMEOUT_CYC + 1);

  if (OFFSET_CYC < ZERO_SEEK_CYC
      || SEEK_TIMEOUT_CYC < OFFSET_CYC) begin : g_chk
    $error("Timer parameters out of order");
  end

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] rawIn;
  logic [SYNC_W-1:0] syncA;
  logic [SYNC_W-1:0] syncB;
  assign rawIn = {addrPlugIn, plugFittedIn, tagIn, busIn, sect32SelIn,
                  servoIndexIn, servoSectorIn, dcPowerFaultIn, multiHeadIn,
                  writeCurrentFaultIn, outOfFieldIn, carriageArrivedIn,
                  speedOkIn, headsLoadedIn, writeProtectSwIn,
                  faultClearSwIn, driveInitIn};
  for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        syncA[i] <= 1'b0;
        syncB[i] <= 1'b0;
      end else begin
        syncA[i] <= rawIn[i];
        syncB[i] <= syncA[i];
      end
    end
  end

  logic [2:0] addrIn;
  logic       plugIn;
  logic [2:0] tag;
  logic [9:0] bus;
  logic       sect32In;
  logic       idxIn;
  logic       secIn;
  logic       dcIn;
  logic       multiIn;
  logic       wcurIn;
  logic       fieldIn;
  logic       arrivedIn;
  logic       speedIn;
  logic       loadedIn;
  logic       wpIn;
  logic       clrSwIn;
  logic       initIn;
  assign {addrIn, plugIn, tag, bus, sect32In, idxIn, secIn, dcIn, multiIn,
          wcurIn, fieldIn, arrivedIn, speedIn, loadedIn, wpIn, clrSwIn,
          initIn} = syncB;

  logic [2:0] tagPrev;
  logic       idxPrev;
  logic       secPrev;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tagPrev <= 3'h0;
      idxPrev <= 1'b0;
      secPrev <= 1'b0;
    end else begin
      tagPrev <= tag;
      idxPrev <= idxIn;
      secPrev <= secIn;
    end
  end

  logic idxRise;
  logic secRise;
  logic tag1Rise;
  logic ctlTag;
  logic rtzCmd;
  logic faultClr;
  assign idxRise  = idxIn & ~idxPrev;
  assign secRise  = secIn & ~secPrev;
  assign tag1Rise = tag[0] & ~tagPrev[0];
  assign ctlTag   = tag[2];
  assign rtzCmd   = ctlTag & bus[BIT_RTZ];
  assign faultClr = (ctlTag & bus[BIT_FAULT_CLR]) | clrSwIn | initIn;

  // ---------------------------------------------------------------
  // Unit address plug
  // ---------------------------------------------------------------
  logic [4:0] addrCnt;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      unitAddr  <= 3'h0;
      plugValid <= 1'b0;
      addrCnt   <= 5'h0;
    end else if (plugValid) begin
      if (!plugIn) begin
        plugValid <= 1'b0;
        addrCnt   <= 5'h0;
      end
    end else if (addrCnt < 5'(ADDR_SETUP_CYC)) begin
      addrCnt <= addrCnt + 5'h1;
    end else if (!plugIn || addrIn != unitAddr) begin
      unitAddr <= addrIn;
      addrCnt  <= 5'h0;
    end else begin
      plugValid <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Sector and index timing
  // ---------------------------------------------------------------
  logic       sect32;
  logic [4:0] sectMax;
  logic [7:0] idxCnt;
  logic [6:0] markCnt;
  assign sectMax = sect32 ? MAX_SECT_16 : MAX_SECT_18;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sect32      <= 1'b0;
      sectorCount <= 5'h0;
    end else if (idxRise) begin
      sect32      <= sect32In;
      sectorCount <= 5'h0;
    end else if (secRise && sectorCount < sectMax) begin
      sectorCount <= sectorCount + 5'h1;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      idxCnt     <= 8'h0;
      indexPulse <= 1'b0;
    end else if (idxRise) begin
      idxCnt     <= 8'(INDEX_CYC - 1);
      indexPulse <= 1'b1;
    end else if (idxCnt != 8'h0) begin
      idxCnt <= idxCnt - 8'h1;
    end else begin
      indexPulse <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      markCnt    <= 7'h0;
      sectorMark <= 1'b0;
    end else if (idxRise || secRise) begin
      markCnt    <= 7'(SECT_MARK_CYC - 1);
      sectorMark <= 1'b1;
    end else if (markCnt != 7'h0) begin
      markCnt <= markCnt - 7'h1;
    end else begin
      sectorMark <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Head and control registers
  // ---------------------------------------------------------------
  drive_ctrl_t ctrl;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      headSel <= HEAD_RESET;
    end else if (rtzCmd || initIn) begin
      headSel <= HEAD_RESET;
    end else if (tag[1]) begin
      headSel <= bus[2:0];
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= '0;
    end else if (initIn) begin
      ctrl <= '0;
    end else if (ctlTag) begin
      ctrl.writeGate   <= bus[BIT_WRITE_GATE];
      ctrl.readGate    <= bus[BIT_READ_GATE];
      ctrl.offsetPlus  <= bus[BIT_OFS_PLUS];
      ctrl.offsetMinus <= bus[BIT_OFS_MINUS];
    end
  end

  // ---------------------------------------------------------------
  // Fault latches
  // ---------------------------------------------------------------
  seek_state_t           seekState;
  logic                  onCyl;
  logic [NUM_FAULTS-1:0] cause;
  logic [NUM_FAULTS-1:0] faultLatch;
  logic                  faultNow;
  assign onCyl = (seekState == SK_IDLE);
  assign cause[FLT_DC]       = dcIn;
  assign cause[FLT_HEAD]     = multiIn;
  assign cause[FLT_WRITE]    = wcurIn;
  assign cause[FLT_OFF_CYL]  = (ctrl.writeGate | ctrl.readGate) & ~onCyl;
  assign cause[FLT_WR_IN_RD] = ctlTag & bus[BIT_WRITE_GATE] & ctrl.readGate;
  assign faultNow = (|cause) | (|faultLatch);
  for (genvar f = 0; f < NUM_FAULTS; f++) begin : g_fault
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        faultLatch[f] <= 1'b0;
      end else begin
        faultLatch[f] <= cause[f] | (faultLatch[f] & ~faultClr);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      writeEnable <= 1'b0;
      readEnable  <= 1'b0;
      offsetPlus  <= 1'b0;
      offsetMinus <= 1'b0;
    end else begin
      writeEnable <= ctrl.writeGate & ~faultNow & ~wpIn
                     & onCyl;
      readEnable  <= ctrl.readGate & onCyl;
      offsetPlus  <= ctrl.offsetPlus;
      offsetMinus <= ctrl.offsetMinus;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      write_lock_error <= 1'b0;
    end else begin
      write_lock_error <= (wpIn & ctlTag & bus[BIT_WRITE_GATE])
                          | (write_lock_error & ~faultClr);
    end
  end

  // ---------------------------------------------------------------
  // Carriage positioning
  // ---------------------------------------------------------------
  logic [9:0]       curCyl;
  logic [9:0]       targetCyl;
  logic [TMR_W-1:0] seekTmr;
  logic             seekErr;
  logic             rangeErr;
  logic             timeoutErr;
  logic             ofsChange;
  assign rangeErr   = tag1Rise & (bus > MAX_CYL);
  assign timeoutErr = (seekState == SK_MOVE)
                      && seekTmr >= TMR_W'(SEEK_TIMEOUT_CYC);
  assign ofsChange  = ctlTag && (bus[BIT_OFS_PLUS] != ctrl.offsetPlus
                      || bus[BIT_OFS_MINUS] != ctrl.offsetMinus);
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      seekState <= SK_IDLE;
      curCyl    <= 10'h0;
      targetCyl <= 10'h0;
      seekTmr   <= '0;
    end else if (rtzCmd) begin
      seekState <= SK_RTZ;
      targetCyl <= 10'h0;
      seekTmr   <= '0;
    end else begin
      case (seekState)
        SK_IDLE: begin
          if (rangeErr) begin
            targetCyl <= curCyl + 10'h1;
            seekTmr   <= '0;
            seekState <= SK_MOVE;
          end else if (tag1Rise && bus == curCyl) begin
            seekTmr   <= TMR_W'(ZERO_SEEK_CYC);
            seekState <= SK_SETTLE;
          end else if (tag1Rise) begin
            targetCyl <= bus;
            seekTmr   <= '0;
            seekState <= SK_MOVE;
          end else if (ofsChange) begin
            seekTmr   <= TMR_W'(OFFSET_CYC);
            seekState <= SK_SETTLE;
          end
        end
        SK_MOVE, SK_RTZ: begin
          seekTmr <= seekTmr + 1'b1;
          if (arrivedIn) begin
            curCyl    <= targetCyl;
            seekState <= SK_IDLE;
          end else if (timeoutErr) begin
            seekState <= SK_IDLE;
          end
        end
        SK_SETTLE: begin
          if (seekTmr > TMR_W'(1)) begin
            seekTmr <= seekTmr - 1'b1;
          end else begin
            seekState <= SK_IDLE;
          end
        end
        default: seekState <= SK_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      seekErr <= 1'b0;
    end else begin
      seekErr <= rangeErr | timeoutErr | fieldIn
                 | (seekErr & ~(rtzCmd | initIn));
    end
  end

  // ---------------------------------------------------------------
  // Status lines
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      status <= '0;
    end else begin
      status.fault          <= faultNow;
      status.seekError      <= seekErr | rangeErr;
      status.onCylinder     <= onCyl;
      status.unitReady      <= speedIn & loadedIn & ~faultNow;
      status.writeProtected <= wpIn;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_PLUG_GONE: assert property (!plugIn |=> !plugValid)
    else $error("presence stayed after plug removal");
  AST_ADDR_SETUP: assert property (
    $rose(plugValid) |-> $past(unitAddr, 20) == unitAddr)
    else $error("address not stable before presence");
  AST_ADDR_HOLD: assert property (
    $fell(plugValid) |=> $stable(unitAddr) [*8])
    else $error("address changed after plug removal");
  AST_SECT_MAX: assert property (sectorCount <= sectMax)
    else $error("sector count above limit");
  AST_INDEX_ZERO: assert property (
    idxRise |=> sectorCount == 5'h0 && indexPulse)
    else $error("index did not restart count");
  AST_MARK_WIDTH: assert property (
    $rose(sectorMark) |-> sectorMark [*8])
    else $error("sector mark too short");
  AST_FAULT_OUT: assert property (|faultLatch |=> status.fault)
    else $error("latched fault not reported");
  AST_WRITE_BLOCK: assert property (faultNow |=> !writeEnable)
    else $error("write enabled during fault");
  AST_FAULT_KEPT: assert property (
    (|faultLatch) && !faultClr |=> |faultLatch)
    else $error("fault lost without clear");
  AST_RANGE_FAST: assert property (
    rangeErr |=> status.seekError ##1 status.seekError)
    else $error("range error not flagged in time");
  AST_RTZ_CLEAR: assert property (
    rtzCmd && !rangeErr && !timeoutErr && !fieldIn |=> !seekErr)
    else $error("return to zero kept seek error");
  AST_READY: assert property (
    status.unitReady |-> $past(speedIn && loadedIn && !faultNow))
    else $error("ready without its conditions");
  AST_PROTECT: assert property (wpIn |=> !writeEnable)
    else $error("write enabled while protected");

  COV_PLUG: cover property ($rose(plugValid));
  COV_SEEK_ERR: cover property ($rose(status.seekError));
  COV_OFFSET: cover property (ofsChange && seekState == SK_IDLE);
  COV_INDEX: cover property (idxRise && sectorCount == sectMax);
endmodule

/* File: design/disk_tag_pkg.sv */
// Purpose: Shared constants and types for the drive tag bus interface
// Assumes: 100 MHz system clock
// Notes:   Times are given in ns, cycle counts derive from them
package disk_tag_pkg;
  localparam int CLK_PERIOD_NS   = 10;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int ADDR_SETUP_NS   = 200;
  localparam int ADDR_SETUP_CYC  = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int SECT_MARK_NS    = 1250;
  localparam int SECT_MARK_CYC   = SECT_MARK_NS / CLK_PERIOD_NS;
  localparam int INDEX_NS        = 2500;
  localparam int INDEX_CYC       = INDEX_NS / CLK_PERIOD_NS;
  localparam int ZERO_SEEK_NS    = 30000;
  localparam int ZERO_SEEK_CYC   = ZERO_SEEK_NS / CLK_PERIOD_NS;
  localparam int OFFSET_NS       = 2750000;
  localparam int SEEK_TIMEOUT_NS = 500000000;
  // ---------------------------------------------------------------
  // Limits and field positions
  // ---------------------------------------------------------------
  localparam logic [9:0] MAX_CYL     = 10'd822;
  localparam logic [4:0] MAX_SECT_18 = 5'd29;
  localparam logic [4:0] MAX_SECT_16 = 5'd31;
  localparam logic [2:0] HEAD_RESET  = 3'h0;
  localparam int BIT_WRITE_GATE = 0;
  localparam int BIT_READ_GATE  = 1;
  localparam int BIT_OFS_PLUS   = 2;
  localparam int BIT_OFS_MINUS  = 3;
  localparam int BIT_FAULT_CLR  = 4;
  localparam int BIT_RTZ        = 6;
  localparam int FLT_DC         = 0;
  localparam int FLT_HEAD       = 1;
  localparam int FLT_WRITE      = 2;
  localparam int FLT_OFF_CYL    = 3;
  localparam int FLT_WR_IN_RD   = 4;
  localparam int NUM_FAULTS     = 5;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic fault;
    logic seekError;
    logic onCylinder;
    logic unitReady;
    logic writeProtected;
  } drive_status_t;
  typedef struct packed {
    logic writeGate;
    logic readGate;
    logic offsetPlus;
    logic offsetMinus;
  } drive_ctrl_t;
  typedef enum logic [3:0] {
    SK_IDLE   = 4'b0001,
    SK_MOVE   = 4'b0010,
    SK_SETTLE = 4'b0100,
    SK_RTZ    = 4'b1000
  } seek_state_t;
endpackage

/* File: verification/adapter_model.sv */
// Purpose: Adapter side model driving the tag lines and bus
// Assumes: Caller starts just after a rising edge
// Notes:   A released bus shows the inverse of its last value
module adapter_model (
  input  wire logic       clk_sys,
  output logic      [2:0] tagIn,
  output logic      [9:0] busIn
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tagIn = 3'h0;
    busIn = 10'h000;
  end
  // Bus settles a cycle ahead of the tag and holds a cycle after it drops
  task automatic sendTag(input int t, input logic [9:0] v, input int hold);
    busIn = v;
    @(posedge clk_sys);
    #1;
    tagIn = 3'h1 << t;
    repeat (hold) @(posedge clk_sys);
    #1;
    tagIn = 3'h0;
    @(posedge clk_sys);
    #1;
    busIn = ~v;
  endtask
endmodule

/* File: verification/disk_tag_drive_bench.sv */
// Purpose: Self-checking bench for disk_tag_drive
// Assumes: Short offset and seek timeout counts
// Notes:   Checks wait out the four-edge input latency
module disk_tag_drive_bench
  import disk_tag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OFS = 4000;
  localparam int TMO = 5000;
  logic          clk_sys, reset_n, plugFittedIn, sect32SelIn;
  logic [2:0]    addrPlugIn, tagIn, unitAddr, headSel;
  logic [9:0]    busIn;
  logic          servoIndexIn, servoSectorIn, dcPowerFaultIn;
  logic          multiHeadIn, writeCurrentFaultIn, outOfFieldIn;
  logic          carriageArrivedIn, speedOkIn, headsLoadedIn;
  logic          writeProtectSwIn, faultClearSwIn, driveInitIn;
  logic          plugValid, indexPulse, sectorMark, writeEnable;
  logic          readEnable, offsetPlus, offsetMinus, write_lock_error;
  logic [4:0]    sectorCount;
  drive_status_t status;
  int            err_total, comparisons;
  disk_tag_drive #(.OFFSET_CYC(OFS), .SEEK_TIMEOUT_CYC(TMO))
  u_disk_tag_drive (
    .clk_sys, .reset_n, .addrPlugIn, .plugFittedIn, .tagIn, .busIn,
    .sect32SelIn, .servoIndexIn, .servoSectorIn, .dcPowerFaultIn,
    .multiHeadIn, .writeCurrentFaultIn, .outOfFieldIn, .carriageArrivedIn,
    .speedOkIn, .headsLoadedIn, .writeProtectSwIn, .faultClearSwIn,
    .driveInitIn, .unitAddr, .plugValid, .sectorCount, .indexPulse,
    .sectorMark, .status, .writeEnable, .readEnable, .headSel,
    .offsetPlus, .offsetMinus, .write_lock_error);
  adapter_model u_adapter_model (.clk_sys, .tagIn, .busIn);
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkV(input string nm, input logic [9:0] e,
                      input logic [9:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    step(4);
    s = 1'h0;
    step(6);
  endtask
  task automatic ctl(input logic [9:0] v);
    u_adapter_model.sendTag(2, v, 4);
    step(6);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic testPlug;
    addrPlugIn = 3'h5;
    plugFittedIn = 1'h1;
    step(15);
    chk("plugValid", 1'h0, plugValid);
    step(30);
    chk("plugValid", 1'h1, plugValid);
    chkV("unitAddr", 10'h5, 10'(unitAddr));
    plugFittedIn = 1'h0;
    addrPlugIn = 3'h2;
    step(6);
    chk("plugValid", 1'h0, plugValid);
    chkV("unitAddr", 10'h5, 10'(unitAddr));
  endtask
  task automatic sectorRun(input logic sel, input logic [4:0] mx);
    sect32SelIn = sel;
    servoIndexIn = 1'h1;
    step(4);
    servoIndexIn = 1'h0;
    step(2);
    chkV("count", 10'h0, 10'(sectorCount));
    chk("index", 1'h1, indexPulse);
    chk("mark", 1'h1, sectorMark);
    step(113);
    chk("mark", 1'h1, sectorMark);
    step(14);
    chk("mark", 1'h0, sectorMark);
    step(112);
    chk("index", 1'h1, indexPulse);
    step(20);
    chk("index", 1'h0, indexPulse);
    for (int i = 1; i <= 35; i++) begin
      servoSectorIn = 1'h1;
      step(3);
      servoSectorIn = 1'h0;
      step(3);
      if (i == 1) chkV("count", 10'h1, 10'(sectorCount));
    end
    step(4);
    chkV("count", 10'(mx), 10'(sectorCount));
  endtask
  task automatic testSeek;
    u_adapter_model.sendTag(0, 10'h005, 4);
    step(1);
    chk("onCyl", 1'h0, status.onCylinder);
    pulse(carriageArrivedIn);
    chk("onCyl", 1'h1, status.onCylinder);
    u_adapter_model.sendTag(1, 10'h3fc, 4);
    step(6);
    chkV("headSel", 10'h4, 10'(headSel));
    u_adapter_model.sendTag(0, 10'h337, 1);
    step(6);
    chk("seekErr", 1'h1, status.seekError);
    pulse(carriageArrivedIn);
    ctl(10'h040);
    chk("seekErr", 1'h0, status.seekError);
    chkV("headSel", 10'h0, 10'(headSel));
    chk("onCyl", 1'h0, status.onCylinder);
    pulse(carriageArrivedIn);
    chk("onCyl", 1'h1, status.onCylinder);
  endtask
  task automatic testTimeout;
    u_adapter_model.sendTag(0, 10'h00a, 4);
    ctl(10'h002);
    chk("fault", 1'h1, status.fault);
    chk("rdEn", 1'h0, readEnable);
    step(TMO - 100);
    chk("seekErr", 1'h0, status.seekError);
    step(200);
    chk("seekErr", 1'h1, status.seekError);
    chk("onCyl", 1'h1, status.onCylinder);
    chk("fault", 1'h1, status.fault);
    pulse(driveInitIn);
    chk("seekErr", 1'h0, status.seekError);
    outOfFieldIn = 1'h1;
    step(6);
    chk("seekErr", 1'h1, status.seekError);
    outOfFieldIn = 1'h0;
    ctl(10'h040);
    pulse(carriageArrivedIn);
    chk("seekErr", 1'h0, status.seekError);
  endtask
  task automatic testOffset;
    ctl(10'h004);
    chk("ofsPlus", 1'h1, offsetPlus);
    chk("onCyl", 1'h0, status.onCylinder);
    step(OFS - 100);
    chk("onCyl", 1'h0, status.onCylinder);
    step(200);
    chk("onCyl", 1'h1, status.onCylinder);
    ctl(10'h008);
    chk("ofsMinus", 1'h1, offsetMinus);
    chk("ofsPlus", 1'h0, offsetPlus);
    step(OFS + 100);
    ctl(10'h000);
    step(OFS + 100);
  endtask
  task automatic setCause(input int i, input logic v);
    case (i)
      0: dcPowerFaultIn = v;
      1: multiHeadIn = v;
      default: writeCurrentFaultIn = v;
    endcase
  endtask
  task automatic clearBy(input int i);
    case (i)
      0: ctl(10'h010);
      1: pulse(faultClearSwIn);
      default: pulse(driveInitIn);
    endcase
  endtask
  task automatic testFaults;
    for (int i = 0; i < 3; i++) begin
      ctl(10'h001);
      chk("wrEn", 1'h1, writeEnable);
      chk("ready", 1'h1, status.unitReady);
      setCause(i, 1'h1);
      step(6);
      chk("fault", 1'h1, status.fault);
      chk("wrEn", 1'h0, writeEnable);
      chk("ready", 1'h0, status.unitReady);
      clearBy(i);
      chk("fault", 1'h1, status.fault);
      setCause(i, 1'h0);
      step(6);
      chk("fault", 1'h1, status.fault);
      clearBy(i);
      chk("fault", 1'h0, status.fault);
    end
    ctl(10'h002);
    chk("rdEn", 1'h1, readEnable);
    ctl(10'h003);
    chk("fault", 1'h1, status.fault);
    ctl(10'h010);
    chk("fault", 1'h0, status.fault);
    speedOkIn = 1'h0;
    step(6);
    chk("ready", 1'h0, status.unitReady);
    speedOkIn = 1'h1;
  endtask
  task automatic testProtect;
    writeProtectSwIn = 1'h1;
    step(6);
    chk("wrProt", 1'h1, status.writeProtected);
    ctl(10'h001);
    chk("lockErr", 1'h1, write_lock_error);
    chk("wrEn", 1'h0, writeEnable);
    writeProtectSwIn = 1'h0;
    pulse(driveInitIn);
    chk("lockErr", 1'h0, write_lock_error);
  endtask
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #400000;
    err_total++;
    stop_test();
  end
  initial begin
    {reset_n, addrPlugIn, plugFittedIn, sect32SelIn, servoIndexIn} = '0;
    {servoSectorIn, dcPowerFaultIn, multiHeadIn, writeCurrentFaultIn} = '0;
    {outOfFieldIn, carriageArrivedIn, writeProtectSwIn} = '0;
    {faultClearSwIn, driveInitIn} = '0;
    {speedOkIn, headsLoadedIn} = 2'h3;
    step(10);
    chkV("status", 10'h0, 10'(status));
    reset_n = 1'h1;
    step(3);
    chk("onCyl", 1'h1, status.onCylinder);
    testPlug();
    sectorRun(1'h0, MAX_SECT_18);
    sectorRun(1'h1, MAX_SECT_16);
    testSeek();
    testTimeout();
    testOffset();
    testFaults();
    testProtect();
    stop_test();
  end
endmodule
